// file: step11_regs.sv
// Wishbone slave holding the sequencer step eleven setup register
`timescale 1ns/100ps
module step11_regs
  import step11_pkg::*;
(
  input wire logic clk_i, // Clock, 200 MHz
  input wire logic rst_i, // Synchronous reset, high
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Strobe
  input wire logic we_i, // Write enable
  input wire logic [9:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte selects
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Acknowledge
  output logic step_enable_o, // Step included in sequence
  output logic [2:0] gain_o, // Gain factor 1, 2 or 4
  output logic [3:0] pos_input_o, // Positive input code
  output logic internal_o, // Internal source selected
  output logic neg_ext7_o // Negative input is input seven
);
  logic [15:0] setup_q;
  logic [15:0] setup_d;
  logic [31:0] dat_q;
  logic ack_q;
  logic [2:0] gain_w;
  logic internal_w;
  logic neg_w;
  logic [2:0] gain_q;
  logic internal_q;
  logic neg_q;
  logic [15:0] lane_w;

  // One decode of the register address, shared by bus logic and checks
  function automatic logic addr_hit(input logic [9:0] adr);
    return adr == SETUP_ADDR;
  endfunction

  wire req_w = cyc_i & stb_i & ~ack_q;
  wire hit_w = addr_hit(adr_i);
  wire wr_w = req_w & we_i & hit_w;
  wire rd_w = req_w & ~we_i & hit_w;
  wire [31:0] rd_word_w = {16'h0000, setup_q & SETUP_WMASK}; // see RQ7

  // Byte lanes 3:2 carry nothing of this register
  for (genvar b = 0; b < 2; b++) begin : g_lane
    assign lane_w[b*8 +: 8] = {8{sel_i[b]}};
  end
  wire [15:0] lane_mask_w = lane_w & SETUP_WMASK; // see RQ7

  assign setup_d = wr_w ? ((setup_q & ~lane_mask_w) | (dat_i[15:0] & lane_mask_w))
                        : setup_q; // see RQ1

  step11_route u_route (
    .gain_code_i(setup_q[GAIN_HI:GAIN_LO]),
    .pos_code_i(setup_q[POS_HI:0]),
    .neg_sel_i(setup_q[NEG_BIT]),
    .gain_o(gain_w),
    .internal_o(internal_w),
    .neg_ext7_o(neg_w)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_q <= SETUP_RESET; // see RQ4
    end else begin
      setup_q <= setup_d;
    end
  end

  // Registered answer: ack and data stand for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_w;
      dat_q <= rd_w ? rd_word_w : 32'h0000_0000;
    end
  end

  // Decoded routing, one cycle behind the register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_q <= GAIN_X1;
      internal_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      gain_q <= gain_w;
      internal_q <= internal_w;
      neg_q <= neg_w; // see RQ3
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign step_enable_o = setup_q[ENABLE_BIT];
  assign pos_input_o = setup_q[POS_HI:0];
  assign gain_o = gain_q;
  assign internal_o = internal_q;
  assign neg_ext7_o = neg_q;

  AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ7
    ack_o |-> dat_o[31:16] == 16'h0000 && dat_o[12:5] == 8'h00)
    else $error("reserved bits not zero");
  AST_WRITE_TAKES: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
    wr_w && sel_i[1] |=> step_enable_o == $past(dat_i[15]))
    else $error("enable bit not written");
  AST_GAIN_MAP: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ2
    ##1 gain_o == ($past(setup_q[14:13]) == 2'h0 ? 3'h1 :
                   $past(setup_q[14:13]) == 2'h1 ? 3'h2 : 3'h4))
    else $error("gain decode wrong");
  AST_NEG_IGNORED: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ6
    setup_q[3] |=> !neg_ext7_o)
    else $error("negative select not ignored");
  AST_NEG_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ3
    !setup_q[3] |=> neg_ext7_o == $past(setup_q[4]))
    else $error("negative select wrong");
  AST_INTERNAL: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ5
    1'b1 |=> internal_o == $past(setup_q[3]))
    else $error("internal flag wrong");
  AST_POS_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ4
    wr_w && sel_i[0] |=> pos_input_o == $past(dat_i[3:0]))
    else $error("positive select not written");
  AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");

  // Bus handshake
  AST_ACK_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o
    |=> ack_o)
    else $error("request not acknowledged");
  AST_ACK_NEEDS_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i)
    |=> !ack_o)
    else $error("ack without request");
  AST_WR_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w
    |=> !wr_w)
    else $error("write taken twice");
  AST_DAT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o
    |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");

  // Read and write paths
  AST_READ_DATA: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ7
    rd_w
    |=> dat_o == {16'h0000, $past(setup_q) & 16'hE01F})
    else $error("read data wrong");
  AST_UNMAPPED_READ: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ7
    req_w && !we_i && !hit_w
    |=> dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_UNMAPPED_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ7
    req_w && we_i && !addr_hit(adr_i)
    |=> $stable(setup_q))
    else $error("unmapped write changed register");
  AST_IDLE_STABLE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
    !wr_w
    |=> $stable(setup_q))
    else $error("register changed without write");
  AST_GAIN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ2
    wr_w && sel_i[1]
    |=> setup_q[14:13] == $past(dat_i[14:13]))
    else $error("gain field not written");
  AST_HIGH_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
    wr_w && !sel_i[1]
    |=> $stable(setup_q[15:8]))
    else $error("unselected high byte changed");
  AST_NEG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ3
    wr_w && sel_i[0]
    |=> setup_q[4] == $past(dat_i[4]))
    else $error("negative select not written");
  AST_LOW_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ4
    wr_w && !sel_i[0]
    |=> $stable(setup_q[7:0]))
    else $error("unselected low byte changed");
  AST_RESV_STORED: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ7
    setup_q[12:5] == 8'h00)
    else $error("reserved bits stored");

  // Decoded outputs
  AST_GAIN_ONEHOT: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ2
    $onehot(gain_o))
    else $error("gain factor not one-hot");
  AST_GAIN_X4: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ2
    setup_q[GAIN_HI]
    |=> gain_o == GAIN_X4)
    else $error("upper gain codes not four");
  AST_INT_NEG: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ6
    internal_o
    |-> !neg_ext7_o)
    else $error("negative routed with internal source");
  AST_NEG_EXT7: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ3
    neg_ext7_o
    |-> $past(setup_q[NEG_BIT]) && !$past(setup_q[POS_HI]))
    else $error("input seven routed wrongly");
  AST_POS_INT: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ5
    pos_input_o >= POS_FIRST_INTERNAL
    |=> internal_o)
    else $error("internal code not flagged");

  // Values right after reset
  AST_ENABLE_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ1
    $fell(rst_i)
    |-> !step_enable_o)
    else $error("enable not zero after reset");
  AST_POS_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ4
    $fell(rst_i)
    |-> pos_input_o == 4'hB)
    else $error("positive select reset wrong");
  AST_GAIN_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ2 RQ3
    $fell(rst_i)
    |-> gain_o == GAIN_X1 && !neg_ext7_o)
    else $error("gain or negative reset wrong");
  AST_INTERNAL_RESET: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ5
    $fell(rst_i)
    |-> !internal_o ##1 internal_o)
    else $error("internal flag reset wrong");

  COV_WRITE: cover property (@(posedge clk_i) wr_w);
  COV_READ: cover property (@(posedge clk_i) ack_o && !we_i && hit_w);
  COV_INTERNAL_NEG: cover property (@(posedge clk_i) internal_o && setup_q[4]);
  COV_SHORT_ON: cover property (@(posedge clk_i) pos_input_o == POS_SHORT && step_enable_o);
  COV_GAIN4_INT: cover property (@(posedge clk_i) gain_o == GAIN_X4 && internal_o);
endmodule

// file: step11_pkg.sv
// Constants for the sequencer step eleven setup register
// What this block does
// RQ1 - Enable bit 15, read/write, resets zero
// RQ2 - Gain field 14:13, codes give 1,2,4,4
// RQ3 - Negative select bit 4, ground or input seven
// RQ4 - Positive select 3:0, resets to 1011
// RQ5 - Codes 1000-1111 pick internal sources
// RQ6 - Internal source ignores negative select bit
// RQ7 - Bits 12:5 read zero, ignore writes
package step11_pkg;
  localparam logic [7:0] SETUP_INDEX = 8'h9B;
  localparam logic [9:0] SETUP_ADDR = {SETUP_INDEX, 2'b00};
  localparam int ENABLE_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam logic [15:0] SETUP_RESET = 16'h000B;
  localparam logic [15:0] SETUP_WMASK = 16'hE01F;
  localparam logic [3:0] POS_FIRST_INTERNAL = 4'h8;
  localparam logic [3:0] POS_TEMP = 4'h8;
  localparam logic [3:0] POS_SHORT = 4'h9;
  localparam logic [3:0] POS_TEST = 4'hA;
  localparam logic [3:0] POS_IO_SUPPLY = 4'hC;
  localparam logic [3:0] POS_CORE_SUPPLY = 4'hD;
  localparam logic [3:0] POS_ANALOG_PWR = 4'hE;
  localparam logic [3:0] POS_DIGITAL_PWR = 4'hF;
  localparam logic [2:0] GAIN_X1 = 3'h1;
  localparam logic [2:0] GAIN_X2 = 3'h2;
  localparam logic [2:0] GAIN_X4 = 3'h4;
endpackage

// file: step11_route.sv
// Decode of the step eleven fields into converter routing
`timescale 1ns/100ps
module step11_route
  import step11_pkg::*;
(
  input wire logic [1:0] gain_code_i, // Gain field
  input wire logic [3:0] pos_code_i, // Positive select field
  input wire logic neg_sel_i, // Negative select bit
  output logic [2:0] gain_o, // Gain factor
  output logic internal_o, // Positive picks internal source
  output logic neg_ext7_o // Negative routed to input seven
);
  assign gain_o = (gain_code_i == 2'h0) ? GAIN_X1 :
                  (gain_code_i == 2'h1) ? GAIN_X2 : GAIN_X4; // see RQ2
  assign internal_o = (pos_code_i >= POS_FIRST_INTERNAL); // see RQ5
  assign neg_ext7_o = neg_sel_i & ~internal_o; // see RQ6
endmodule

// file: sequencer_step11_config_test.sv
// Self-checking bench for the step eleven setup register
`timescale 1ns/100ps
module sequencer_step11_config_test;
  import step11_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [9:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic ack_o, step_enable_o, internal_o, neg_ext7_o;
  logic [2:0] gain_o;
  logic [3:0] pos_input_o;
  logic [15:0] model_q = SETUP_RESET;
  int error_cnt = 0, n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  step11_regs dut(.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .step_enable_o(step_enable_o), .gain_o(gain_o), .pos_input_o(pos_input_o),
    .internal_o(internal_o), .neg_ext7_o(neg_ext7_o));
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
    bus(1'b1, a, s, d);
    if (a == SETUP_ADDR && s[1]) model_q[15:8] = d[15:8] & SETUP_WMASK[15:8];
    if (a == SETUP_ADDR && s[0]) model_q[7:0] = d[7:0] & SETUP_WMASK[7:0];
  endtask
  function automatic logic [2:0] gain_of(input logic [1:0] c);
    return (c == 2'h0) ? 3'h1 : (c == 2'h1) ? 3'h2 : 3'h4;
  endfunction
  task automatic verify();
    bus(1'b0, SETUP_ADDR, 4'hF, 32'h0);
    check(rd, {16'h0, model_q});
    check({step_enable_o, gain_o, pos_input_o, internal_o, neg_ext7_o}, {model_q[15],
      gain_of(model_q[14:13]), model_q[3:0], model_q[3], model_q[4] & ~model_q[3]});
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    void'($urandom(17358));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    verify();
    $display("reset test done");
    for (int c = 0; c < 16; c++) begin
      wr(SETUP_ADDR, 4'h3, {16'h0, c[0], c[1:0], 8'hFF, 1'b1, c[3:0]});
      verify();
    end
    $display("code sweep done");
    wr(10'h3FC, 4'hF, 32'hFFFFFFFF);
    verify();
    bus(1'b0, 10'h3FC, 4'hF, 32'h0);
    check(rd, 32'h0);
    repeat (40) begin
      wr(SETUP_ADDR, 4'($urandom), $urandom);
      verify();
    end
    $display("random test done");
    finish_test();
  end
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
endmodule
